// [pkg/clk_gate_pkg.sv]
// constants, register map and unit layout of the peripheral clock-gating block
package clk_gate_pkg;

	// =========================================================
	// bus and register offsets
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIG_OFS    = 12'h060;
	localparam logic [ADDR_W-1:0] RUN_MODE_GATE_ONE_OFS   = 12'h100;
	localparam logic [ADDR_W-1:0] RUN_MODE_GATE_TWO_OFS   = 12'h108;
	localparam logic [ADDR_W-1:0] SLEEP_MODE_GATE_ONE_OFS = 12'h110;
	localparam logic [ADDR_W-1:0] SLEEP_MODE_GATE_TWO_OFS = 12'h118;
	localparam logic [ADDR_W-1:0] DEEP_SLEEP_GATE_ONE_OFS = 12'h124;
	localparam logic [ADDR_W-1:0] DEEP_SLEEP_GATE_TWO_OFS = 12'h128;
	localparam logic [ADDR_W-1:0] FAULT_STATUS_OFS        = 12'h150;
	localparam logic [ADDR_W-1:0] FAULT_ENABLE_OFS        = 12'h154;
	localparam logic [ADDR_W-1:0] FAULT_CLEAR_OFS         = 12'h158;

	// =========================================================
	// field positions
	localparam int GPTIMER_ZERO_BIT    = 16;
	localparam int TWO_WIRE_ZERO_BIT   = 12;
	localparam int SYNC_SERIAL_ONE_BIT = 5;
	localparam int SYNC_SERIAL_ZERO_BIT = 4;
	localparam int ASYNC_SERIAL_ONE_BIT = 1;
	localparam int ASYNC_SERIAL_ZERO_BIT = 0;
	localparam int ETH_PHY_BIT         = 30;
	localparam int ETH_MAC_BIT         = 28;
	localparam int PORT_G_BIT          = 6;
	localparam int AUTO_CLOCK_GATING_BIT = 27;

	// writable bits; every other position is reserved and reads zero
	localparam logic [DATA_W-1:0] GATE_ONE_MASK = 32'h0001_1033;
	localparam logic [DATA_W-1:0] GATE_TWO_MASK = 32'h5000_0040;

	// =========================================================
	// reset values
	localparam logic [DATA_W-1:0] GATE_RESET   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CONFIG_RESET = 32'h0000_0000;

	// =========================================================
	// gated units, one index each
	localparam int NUM_UNITS = 9;
	localparam logic [NUM_UNITS-1:0] UNITS_RESET = 9'h000;
	localparam int U_GPTIMER_ZERO      = 0;
	localparam int U_TWO_WIRE_ZERO     = 1;
	localparam int U_SYNC_SERIAL_ONE   = 2;
	localparam int U_SYNC_SERIAL_ZERO  = 3;
	localparam int U_ASYNC_SERIAL_ONE  = 4;
	localparam int U_ASYNC_SERIAL_ZERO = 5;
	localparam int U_ETH_PHY           = 6;
	localparam int U_ETH_MAC           = 7;
	localparam int U_PORT_G            = 8;

	// =========================================================
	// power states
	typedef enum logic [1:0] {
		PWR_RUN   = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_DEEP  = 2'b10
	} power_mode_t;

endpackage : clk_gate_pkg

// [core/peripheral_clock_gating.sv]
// peripheral clock-gating registers, gate outputs and bus-fault logic
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// =========================================================
// Overview of operation
// - deep gate one bit 16 clocks timer 0
// - deep gate one bit 12 clocks two-wire 0
// - bits 5 and 4 clock sync serial units
// - bits 1 and 0 clock async serial units
// - gate one reserved ranges read zero, read-only
// - access to unclocked unit answers with bus fault
// - all gate bits reset to zero
// - run gate two at 0x108, sleep variants alike
// - auto gating applies sleep and deep registers
// - run gate two bit 30 clocks ethernet phy
// - run gate two bit 28 clocks ethernet mac
// - run gate two bit 6 clocks port G
// - gate two reserved bits read zero, read-only
// - positions without a unit act reserved
module peripheral_clock_gating
	import clk_gate_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	input  wire logic [ADDR_W-1:0]    regAddr,
	input  wire logic [DATA_W-1:0]    regWrData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic      [DATA_W-1:0]    regRdData,
	input  wire logic                 sleepReq,
	input  wire logic                 deepSleepReq,
	input  wire logic [NUM_UNITS-1:0] unitAccess,
	output logic                      busFault,
	output logic                      gptimerZeroClkEn,
	output logic                      twoWireZeroClkEn,
	output logic                      syncSerialOneClkEn,
	output logic                      syncSerialZeroClkEn,
	output logic                      asyncSerialOneClkEn,
	output logic                      asyncSerialZeroClkEn,
	output logic                      ethPhyClkEn,
	output logic                      ethMacClkEn,
	output logic                      portGClkEn,
	output logic                      faultIrq
);

	// =========================================================
	// helpers
	function automatic logic [NUM_UNITS-1:0] unitsOf(
		input logic [DATA_W-1:0] one,
		input logic [DATA_W-1:0] two
	);
		logic [NUM_UNITS-1:0] u;
		u = '0;
		u[U_GPTIMER_ZERO]      = one[GPTIMER_ZERO_BIT];
		u[U_TWO_WIRE_ZERO]     = one[TWO_WIRE_ZERO_BIT];
		u[U_SYNC_SERIAL_ONE]   = one[SYNC_SERIAL_ONE_BIT];
		u[U_SYNC_SERIAL_ZERO]  = one[SYNC_SERIAL_ZERO_BIT];
		u[U_ASYNC_SERIAL_ONE]  = one[ASYNC_SERIAL_ONE_BIT];
		u[U_ASYNC_SERIAL_ZERO] = one[ASYNC_SERIAL_ZERO_BIT];
		u[U_ETH_PHY]           = two[ETH_PHY_BIT];
		u[U_ETH_MAC]           = two[ETH_MAC_BIT];
		u[U_PORT_G]            = two[PORT_G_BIT];
		return u;
	endfunction : unitsOf

	function automatic logic hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		return a == ofs;
	endfunction : hit

	// =========================================================
	// register storage
	logic [DATA_W-1:0]    runOne_q;
	logic [DATA_W-1:0]    runTwo_q;
	logic [DATA_W-1:0]    sleepOne_q;
	logic [DATA_W-1:0]    sleepTwo_q;
	logic [DATA_W-1:0]    deepOne_q;
	logic [DATA_W-1:0]    deepTwo_q;
	logic                 autoGate_q;
	logic [NUM_UNITS-1:0] faultStatus_q;
	logic [NUM_UNITS-1:0] faultEnable_q;
	logic [NUM_UNITS-1:0] clkEn_q;
	logic [NUM_UNITS-1:0] clkEn_d;
	logic                 busFault_q;
	logic [DATA_W-1:0]    rdData_q;
	logic [DATA_W-1:0]    rdData_d;
	logic [NUM_UNITS-1:0] faultHit;
	logic [NUM_UNITS-1:0] faultClear;
	power_mode_t          mode;

	// reserved positions are masked at write time, so they never hold a one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			runOne_q   <= GATE_RESET;
			runTwo_q   <= GATE_RESET;
			sleepOne_q <= GATE_RESET;
			sleepTwo_q <= GATE_RESET;
			deepOne_q  <= GATE_RESET;
			deepTwo_q  <= GATE_RESET;
		end else if (regWrite) begin
			if (hit(regAddr, RUN_MODE_GATE_ONE_OFS)) begin
				runOne_q <= regWrData & GATE_ONE_MASK;
			end
			if (hit(regAddr, RUN_MODE_GATE_TWO_OFS)) begin
				runTwo_q <= regWrData & GATE_TWO_MASK;
			end
			if (hit(regAddr, SLEEP_MODE_GATE_ONE_OFS)) begin
				sleepOne_q <= regWrData & GATE_ONE_MASK;
			end
			if (hit(regAddr, SLEEP_MODE_GATE_TWO_OFS)) begin
				sleepTwo_q <= regWrData & GATE_TWO_MASK;
			end
			if (hit(regAddr, DEEP_SLEEP_GATE_ONE_OFS)) begin
				deepOne_q <= regWrData & GATE_ONE_MASK;
			end
			if (hit(regAddr, DEEP_SLEEP_GATE_TWO_OFS)) begin
				deepTwo_q <= regWrData & GATE_TWO_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			autoGate_q <= CONFIG_RESET[AUTO_CLOCK_GATING_BIT];
		end else if (regWrite && hit(regAddr, RUN_CLOCK_CONFIG_OFS)) begin
			autoGate_q <= regWrData[AUTO_CLOCK_GATING_BIT];
		end
	end

	// =========================================================
	// power state and gate selection
	always_comb begin
		if (deepSleepReq) begin
			mode = PWR_DEEP;
		end else if (sleepReq) begin
			mode = PWR_SLEEP;
		end else begin
			mode = PWR_RUN;
		end
	end

	// deep sleep wins when both requests are high
	always_comb begin
		clkEn_d = unitsOf(runOne_q, runTwo_q);
		if (autoGate_q) begin
			unique case (mode)
				PWR_SLEEP: clkEn_d = unitsOf(sleepOne_q, sleepTwo_q);
				PWR_DEEP:  clkEn_d = unitsOf(deepOne_q, deepTwo_q);
				default:   clkEn_d = unitsOf(runOne_q, runTwo_q);
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			clkEn_q <= UNITS_RESET;
		end else begin
			clkEn_q <= clkEn_d;
		end
	end

	assign gptimerZeroClkEn     = clkEn_q[U_GPTIMER_ZERO];
	assign twoWireZeroClkEn     = clkEn_q[U_TWO_WIRE_ZERO];
	assign syncSerialOneClkEn   = clkEn_q[U_SYNC_SERIAL_ONE];
	assign syncSerialZeroClkEn  = clkEn_q[U_SYNC_SERIAL_ZERO];
	assign asyncSerialOneClkEn  = clkEn_q[U_ASYNC_SERIAL_ONE];
	assign asyncSerialZeroClkEn = clkEn_q[U_ASYNC_SERIAL_ZERO];
	assign ethPhyClkEn          = clkEn_q[U_ETH_PHY];
	assign ethMacClkEn          = clkEn_q[U_ETH_MAC];
	assign portGClkEn           = clkEn_q[U_PORT_G];

	// =========================================================
	// bus fault on access to an unclocked unit
	assign faultHit   = unitAccess & ~clkEn_q;
	assign faultClear = (regWrite && hit(regAddr, FAULT_CLEAR_OFS)) ?
		regWrData[NUM_UNITS-1:0] : '0;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busFault_q <= 1'b0;
		end else begin
			busFault_q <= |faultHit;
		end
	end
	assign busFault = busFault_q;

	// a new fault beats a clear landing in the same cycle
	generate
		for (genvar i = 0; i < NUM_UNITS; i++) begin : g_fault
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					faultStatus_q[i] <= 1'b0;
				end else if (faultHit[i]) begin
					faultStatus_q[i] <= 1'b1;
				end else if (faultClear[i]) begin
					faultStatus_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			faultEnable_q <= UNITS_RESET;
		end else if (regWrite && hit(regAddr, FAULT_ENABLE_OFS)) begin
			faultEnable_q <= regWrData[NUM_UNITS-1:0];
		end
	end

	assign faultIrq = |(faultStatus_q & faultEnable_q);

	// =========================================================
	// read path; unmapped and write-only offsets read zero
	always_comb begin
		rdData_d = '0;
		unique case (regAddr)
			RUN_CLOCK_CONFIG_OFS:    rdData_d[AUTO_CLOCK_GATING_BIT] = autoGate_q;
			RUN_MODE_GATE_ONE_OFS:   rdData_d = runOne_q;
			RUN_MODE_GATE_TWO_OFS:   rdData_d = runTwo_q;
			SLEEP_MODE_GATE_ONE_OFS: rdData_d = sleepOne_q;
			SLEEP_MODE_GATE_TWO_OFS: rdData_d = sleepTwo_q;
			DEEP_SLEEP_GATE_ONE_OFS: rdData_d = deepOne_q;
			DEEP_SLEEP_GATE_TWO_OFS: rdData_d = deepTwo_q;
			FAULT_STATUS_OFS:        rdData_d[NUM_UNITS-1:0] = faultStatus_q;
			FAULT_ENABLE_OFS:        rdData_d[NUM_UNITS-1:0] = faultEnable_q;
			default:                 rdData_d = '0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdData_q <= '0;
		end else if (regRead) begin
			rdData_q <= rdData_d;
		end else begin
			rdData_q <= '0;
		end
	end
	assign regRdData = rdData_q;

endmodule : peripheral_clock_gating

`default_nettype wire

// [verification/peripheral_clock_gating_props.sv]
// assertions on the clock-gating block ports
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gating_props
	import clk_gate_pkg::*;
(
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic [NUM_UNITS-1:0] unitAccess,
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic deepSleepReq,
	input wire logic busFault,
	input wire logic gptimerZeroClkEn,
	input wire logic twoWireZeroClkEn,
	input wire logic syncSerialOneClkEn,
	input wire logic syncSerialZeroClkEn,
	input wire logic asyncSerialOneClkEn,
	input wire logic asyncSerialZeroClkEn,
	input wire logic ethPhyClkEn,
	input wire logic ethMacClkEn,
	input wire logic portGClkEn
);
	// =========================================================
	// helpers
	logic [8:0] en;
	logic autoGate_q;
	assign en = {portGClkEn, ethMacClkEn, ethPhyClkEn, asyncSerialZeroClkEn,
		asyncSerialOneClkEn, syncSerialZeroClkEn, syncSerialOneClkEn,
		twoWireZeroClkEn, gptimerZeroClkEn};
	// mirror of the auto gating bit, the only state the mode checks need
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) autoGate_q <= 1'b0;
		else if (regWrite && regAddr == RUN_CLOCK_CONFIG_OFS)
			autoGate_q <= regWrData[AUTO_CLOCK_GATING_BIT];
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// =========================================================
	// properties
	AST_FAULT: assert property (|(unitAccess & ~en) |=> busFault)
		else $error("no fault on unclocked access");
	AST_QUIET: assert property (!(|(unitAccess & ~en)) |=> !busFault)
		else $error("fault without cause");
	AST_RST: assert property ($rose(nrst) |-> en == 9'h000 && !busFault)
		else $error("enables not clear after reset");
	AST_RSVD_ONE: assert property (regRead && regAddr == DEEP_SLEEP_GATE_ONE_OFS
		|=> (regRdData & ~GATE_ONE_MASK) == 32'h0) else $error("reserved bits set");
	AST_RSVD_TWO: assert property (regRead && regAddr == RUN_MODE_GATE_TWO_OFS
		|=> (regRdData & ~GATE_TWO_MASK) == 32'h0) else $error("reserved bits set");
	AST_SPARE: assert property (regRead && regAddr == RUN_MODE_GATE_ONE_OFS
		|=> (regRdData & ~GATE_ONE_MASK) == 32'h0) else $error("spare bits set");
	AST_RUN_TWO: assert property (regWrite && regAddr == RUN_MODE_GATE_TWO_OFS
		&& !autoGate_q ##1 !regWrite |=> en[8:6] == {$past(regWrData[6], 2),
		$past(regWrData[28], 2), $past(regWrData[30], 2)}) else $error("run enables wrong");
	AST_DEEP_ONE: assert property (regWrite && regAddr == DEEP_SLEEP_GATE_ONE_OFS
		&& autoGate_q && deepSleepReq ##1 !regWrite && deepSleepReq |=> en[5:0] ==
		{$past(regWrData[0], 2), $past(regWrData[1], 2), $past(regWrData[4], 2),
		$past(regWrData[5], 2), $past(regWrData[12], 2), $past(regWrData[16], 2)})
		else $error("deep sleep enables wrong");
endmodule : peripheral_clock_gating_props
bind peripheral_clock_gating peripheral_clock_gating_props chk_u (.*);
`default_nettype wire

// [verification/unit_bus_model.sv]
// bus-side model that strobes one gated unit per access
`timescale 1ns/100ps
`default_nettype none
module unit_bus_model
	import clk_gate_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	input  wire logic                 go,
	input  wire logic [3:0]           sel,
	output logic      [NUM_UNITS-1:0] unitAccess
);
	// =========================================================
	// one-cycle strobe; a unit left gated off is hit on purpose to provoke a fault
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) unitAccess <= '0;
		else unitAccess <= go ? NUM_UNITS'(1) << sel : '0;
	end
endmodule : unit_bus_model
`default_nettype wire

// [verification/test_peripheral_clock_gating.sv]
// self-checking bench for the peripheral clock-gating block
`timescale 1ns/100ps
`default_nettype none
module test_peripheral_clock_gating
	import clk_gate_pkg::*;
;
	logic sys_clk = 0, nrst = 0, regWrite = 0, regRead = 0, sleepReq = 0, deepSleepReq = 0;
	logic go = 0, rdSeen = 0, busFault, faultIrq;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWrData = 32'h0, regRdData, r1, r2, g1, g2, v;
	logic [31:0] q[$];
	logic [3:0] sel = 4'h0;
	logic [8:0] unitAccess;
	wire  [8:0] en;
	wire [31:0] enW = {23'h0, en};
	int n_fail = 0, check_count = 0;
	always #25 sys_clk = ~sys_clk;
	peripheral_clock_gating dut_u (.*, .gptimerZeroClkEn(en[0]), .twoWireZeroClkEn(en[1]),
		.syncSerialOneClkEn(en[2]), .syncSerialZeroClkEn(en[3]), .asyncSerialOneClkEn(en[4]),
		.asyncSerialZeroClkEn(en[5]), .ethPhyClkEn(en[6]), .ethMacClkEn(en[7]),
		.portGClkEn(en[8]));
	unit_bus_model bus_u (.*);
	// =========================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
	endtask : rd
	// one unit access; the fault shows two edges after the request
	task automatic acc(input int i, input logic f);
		@(posedge sys_clk);
		go <= 1'b1;
		sel <= 4'(i);
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		check(32'(busFault), 32'(f));
	endtask : acc
	task automatic settle;
		repeat (3) @(negedge sys_clk);
	endtask : settle
	function automatic logic [31:0] expEn(input logic [31:0] a, input logic [31:0] b);
		return {23'h0, b[6], b[28], b[30], a[0], a[1], a[4], a[5], a[12], a[16]};
	endfunction : expEn
	task automatic report_and_stop;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// =========================================================
	// read data monitor, one note per read
	always @(negedge sys_clk) begin
		if (rdSeen) check(regRdData, q.pop_front());
		rdSeen = regRead;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		report_and_stop();
	end
	// =========================================================
	// tests
	initial begin
		void'($urandom(4486));
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(RUN_MODE_GATE_TWO_OFS, 32'h0);
		rd(DEEP_SLEEP_GATE_ONE_OFS, 32'h0);
		rd(12'h200, 32'h0);
		check(enW, 32'h0);
		$display("test reset done");
		acc(8, 1'b1);
		check(32'(faultIrq), 32'h0);
		wr(FAULT_ENABLE_OFS, 32'h1ff);
		for (int i = 0; i < 8; i++) acc(i, 1'b1);
		rd(FAULT_STATUS_OFS, 32'h1ff);
		check(32'(faultIrq), 32'h1);
		wr(FAULT_CLEAR_OFS, 32'h1ff);
		@(negedge sys_clk);
		check(32'(faultIrq), 32'h0);
		$display("test faults done");
		for (int k = 0; k < 4; k++) begin
			r1 = k ? $urandom() : '1;
			r2 = k ? $urandom() : '1;
			wr(RUN_MODE_GATE_ONE_OFS, r1);
			wr(RUN_MODE_GATE_TWO_OFS, r2);
			rd(RUN_MODE_GATE_TWO_OFS, r2 & 32'h5000_0040);
			rd(RUN_MODE_GATE_ONE_OFS, r1 & 32'h0001_1033);
			v = expEn(r1, r2);
			check(enW, v);
			for (int i = 0; i < 9; i++) acc(i, !v[i]);
		end
		$display("test run gating done");
		wr(RUN_CLOCK_CONFIG_OFS, 32'h0800_0000);
		rd(RUN_CLOCK_CONFIG_OFS, 32'h0800_0000);
		@(posedge sys_clk);
		deepSleepReq <= 1'b1;
		g1 = $urandom();
		g2 = $urandom();
		wr(DEEP_SLEEP_GATE_ONE_OFS, g1);
		wr(DEEP_SLEEP_GATE_TWO_OFS, g2);
		rd(DEEP_SLEEP_GATE_ONE_OFS, g1 & 32'h0001_1033);
		check(enW, expEn(g1, g2));
		wr(SLEEP_MODE_GATE_ONE_OFS, ~g1);
		wr(SLEEP_MODE_GATE_TWO_OFS, ~g2);
		@(posedge sys_clk);
		deepSleepReq <= 1'b0;
		sleepReq <= 1'b1;
		settle();
		check(enW, expEn(~g1, ~g2));
		wr(RUN_CLOCK_CONFIG_OFS, 32'h0);
		settle();
		check(enW, expEn(r1, r2));
		// read-modify-write that keeps the reserved bits as they were read
		wr(RUN_MODE_GATE_TWO_OFS, (r2 & 32'h5000_0040) | 32'h0000_0040);
		settle();
		check(enW, expEn(r1, r2 | 32'h0000_0040));
		$display("test sleep gating done");
		@(posedge sys_clk);
		nrst <= 1'b0;
		@(posedge sys_clk);
		nrst <= 1'b1;
		rd(RUN_MODE_GATE_TWO_OFS, 32'h0);
		check(enW, 32'h0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule : test_peripheral_clock_gating
`default_nettype wire
